// File: ddo_regs.svh
// constants for the delayed digital output selector
// Notes on behaviour
// - result goes to the physical output terminal chosen by a routing setting
// - code 1 drives output while the drive is ready
// - code 2 drives output while the power stage modulates
// - code 3 shows a fault trip, code 4 shows no fault present
// - code 7 shows loss of the live-zero current reference
// - code 8 shows any warning, code 9 shows negative speed
// - code 11 shows speed at reference
// - code 10 shows fixed speed selected, code 12 shows limiter active
// - code 17 shows brake command, code 21 its inverse
// - code 18 shows terminal control place active
// - code 20 shows rotation direction mismatch
// - codes 5, 6, 22 show overtemp, external alarm, thermistor alarm
// - codes 24 to 26 pass fieldbus bits one to three
// - code 27 latches any warning until a reset command
// - code 28 or free selector follows one bit of a signal word
// - rising and falling edges delayed separately per output
// - per output inversion of the delayed signal
// - feedback mismatch raises a warning, after three seconds with the default delay
// - feedback warning waits for a programmable delay
`ifndef DDO_REGS_SVH
`define DDO_REGS_SVH
`define DDO_FN_READY 5'h01
`define DDO_FN_RUN 5'h02
`define DDO_FN_FAULT 5'h03
`define DDO_FN_NOFAULT 5'h04
`define DDO_FN_OVERTEMP 5'h05
`define DDO_FN_EXTALARM 5'h06
`define DDO_FN_REFLOSS 5'h07
`define DDO_FN_WARNING 5'h08
`define DDO_FN_REVERSE 5'h09
`define DDO_FN_FIXSPEED 5'h0A
`define DDO_FN_ATSPEED 5'h0B
`define DDO_FN_LIMITER 5'h0C
`define DDO_FN_BRAKE 5'h11
`define DDO_FN_TERMCTL 5'h12
`define DDO_FN_WRONGDIR 5'h14
`define DDO_FN_BRAKEINV 5'h15
`define DDO_FN_THERM 5'h16
`define DDO_FN_FB1 5'h18
`define DDO_FN_FB2 5'h19
`define DDO_FN_FB3 5'h1A
`define DDO_FN_LATCHWARN 5'h1B
`define DDO_FN_WORDBIT 5'h1C
`define DDO_FN_OFF 5'h00
// register offsets
`define DDO_REG_OUT1_FUNC 4'h0
`define DDO_REG_OUT2_FUNC 4'h1
`define DDO_REG_OUT1_RISE 4'h2
`define DDO_REG_OUT1_FALL 4'h3
`define DDO_REG_OUT2_RISE 4'h4
`define DDO_REG_OUT2_FALL 4'h5
`define DDO_REG_OUT1_FBDLY 4'h6
`define DDO_REG_OUT2_FBDLY 4'h7
`define DDO_REG_CTRL 4'h8
`define DDO_REG_SEL1 4'h9
`define DDO_REG_SEL2 4'hA
`define DDO_REG_STATUS 4'hB
// control register fields
`define DDO_CTL_FLIP1 0
`define DDO_CTL_FLIP2 1
`define DDO_CTL_FBEN1 2
`define DDO_CTL_FBEN2 3
`define DDO_CTL_ROUTE1_LSB 4
`define DDO_CTL_ROUTE2_LSB 8
`define DDO_CTL_FBSEL1_LSB 12
`define DDO_CTL_FBSEL2_LSB 16
// selector word fields: bit index low, word id above
`define DDO_SEL_BIT_LSB 0
`define DDO_SEL_ID_LSB 4
// default feedback delay: three seconds in ticks
`define DDO_FB_DEFAULT 32'h0000_0BB8
`endif

// File: ddo_pkg.sv
// types for the delayed digital output selector
package ddo_pkg;
  typedef enum logic [1:0] {
    DDO_IDLE = 2'b00,
    DDO_RISE_WAIT = 2'b01,
    DDO_HIGH = 2'b11,
    DDO_FALL_WAIT = 2'b10
  } ddo_state_e;
  typedef logic [15:0] ddo_count_t;
endpackage : ddo_pkg

// File: ddo_delay_if.sv
// control and result bundle between the top and one delay channel
`timescale 1ns/1ns
interface ddo_delay_if #(parameter int CW = 16);
  logic src;
  logic [CW-1:0] rise_delay;
  logic [CW-1:0] fall_delay;
  logic [CW-1:0] fb_delay;
  logic flip;
  logic fb_enable;
  logic fb_level;
  logic result;
  logic fb_warning;
  modport top (output src, rise_delay, fall_delay, fb_delay, flip, fb_enable, fb_level,
    input result, fb_warning);
  modport chan (input src, rise_delay, fall_delay, fb_delay, flip, fb_enable, fb_level,
    output result, fb_warning);
endinterface : ddo_delay_if

// File: ddo_delay_chan.sv
// one output channel: edge delays, inversion and feedback watch
`timescale 1ns/1ns
`include "ddo_regs.svh"
module ddo_delay_chan #(
  parameter int CW = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  ddo_delay_if.chan ch
);
  ddo_pkg::ddo_state_e state_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] fb_cnt_q;
  logic delayed_q;
  logic result_q;
  logic warn_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ddo_pkg::DDO_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ddo_pkg::DDO_IDLE: begin
          if (ch.src) begin
            state_q <= ddo_pkg::DDO_RISE_WAIT;
            cnt_q <= '0;
          end
        end
        ddo_pkg::DDO_RISE_WAIT: begin
          if (!ch.src) begin
            state_q <= ddo_pkg::DDO_IDLE;
          end else if (cnt_q >= ch.rise_delay) begin
            state_q <= ddo_pkg::DDO_HIGH;
          end else if (tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ddo_pkg::DDO_HIGH: begin
          if (!ch.src) begin
            state_q <= ddo_pkg::DDO_FALL_WAIT;
            cnt_q <= '0;
          end
        end
        default: begin
          if (ch.src) begin
            state_q <= ddo_pkg::DDO_HIGH;
          end else if (cnt_q >= ch.fall_delay) begin
            state_q <= ddo_pkg::DDO_IDLE;
          end else if (tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      delayed_q <= 1'b0;
    end else begin
      delayed_q <= (state_q == ddo_pkg::DDO_HIGH) || (state_q == ddo_pkg::DDO_FALL_WAIT);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      result_q <= 1'b0;
    end else begin
      result_q <= delayed_q ^ ch.flip;
    end
  end

  // mismatch timer; a match or disabled watch restarts it
  always_ff @(posedge clock) begin
    if (rst) begin
      fb_cnt_q <= '0;
      warn_q <= 1'b0;
    end else if (!ch.fb_enable || (ch.fb_level == result_q)) begin
      fb_cnt_q <= '0;
      warn_q <= 1'b0;
    end else if (fb_cnt_q >= ch.fb_delay) begin
      warn_q <= 1'b1;
    end else if (tick) begin
      fb_cnt_q <= fb_cnt_q + 1'b1;
    end
  end

  assign ch.result = result_q;
  assign ch.fb_warning = warn_q;
endmodule : ddo_delay_chan

// File: ddo_selector.sv
// delayed digital output selector top: status routing, registers, two channels
`timescale 1ns/1ns
`include "ddo_regs.svh"
module ddo_selector #(
  parameter int TICK_DIV = 100000,
  parameter int NTERM = 8,
  parameter int NDIN = 8,
  parameter int NWORD = 16,
  parameter int CW = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic drive_ready,
  input wire logic drive_running,
  input wire logic fault_active,
  input wire logic warning_active,
  input wire logic drive_overtemp,
  input wire logic ext_alarm,
  input wire logic reference_loss,
  input wire logic speed_negative,
  input wire logic fixed_speed_selected,
  input wire logic at_speed,
  input wire logic limiter_active,
  input wire logic brake_command,
  input wire logic terminal_control_active,
  input wire logic direction_mismatch,
  input wire logic thermistor_alarm,
  input wire logic [2:0] fieldbus_bits,
  input wire logic reset_command,
  input wire logic [NWORD*16-1:0] signal_words,
  input wire logic [NDIN-1:0] digital_inputs,
  output logic [NTERM-1:0] terminal_out,
  output logic out1_feedback_warning,
  output logic out2_feedback_warning
);
  localparam int DIVW = $clog2(TICK_DIV);
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(TICK_DIV - 1);

  logic [DIVW-1:0] div_q;
  logic tick_q;
  logic [4:0] out1_function_select_q;
  logic [4:0] out2_function_select_q;
  logic [CW-1:0] out1_rise_delay_q;
  logic [CW-1:0] out1_fall_delay_q;
  logic [CW-1:0] out2_rise_delay_q;
  logic [CW-1:0] out2_fall_delay_q;
  logic [CW-1:0] out1_fb_delay_q;
  logic [CW-1:0] out2_fb_delay_q;
  logic [19:0] ctrl_q;
  logic [15:0] free_bit_selector1_q;
  logic [15:0] free_bit_selector2_q;
  logic [31:0] rdata_q;
  logic latched_warning_q;
  logic [NDIN-1:0] din_meta_q;
  logic [NDIN-1:0] din_sync_q;
  logic [1:0] src_q;
  logic [NTERM-1:0] term_q;
  logic [1:0] fbw_q;
  logic [1:0] chan_result;
  logic [1:0] chan_warn;

  ddo_delay_if #(.CW(CW)) dif1 ();
  ddo_delay_if #(.CW(CW)) dif2 ();

  // control tick for all delay counts
  always_ff @(posedge clock) begin
    if (rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      out1_function_select_q <= `DDO_FN_OFF;
      out2_function_select_q <= `DDO_FN_OFF;
      out1_rise_delay_q <= '0;
      out1_fall_delay_q <= '0;
      out2_rise_delay_q <= '0;
      out2_fall_delay_q <= '0;
      out1_fb_delay_q <= CW'(`DDO_FB_DEFAULT);
      out2_fb_delay_q <= CW'(`DDO_FB_DEFAULT);
      ctrl_q <= '0;
      free_bit_selector1_q <= '0;
      free_bit_selector2_q <= '0;
    end else if (reg_write) begin
      if (reg_addr == `DDO_REG_OUT1_FUNC) begin
        out1_function_select_q <= reg_wdata[4:0];
      end else if (reg_addr == `DDO_REG_OUT2_FUNC) begin
        out2_function_select_q <= reg_wdata[4:0];
      end else if (reg_addr == `DDO_REG_OUT1_RISE) begin
        out1_rise_delay_q <= reg_wdata[CW-1:0];
      end else if (reg_addr == `DDO_REG_OUT1_FALL) begin
        out1_fall_delay_q <= reg_wdata[CW-1:0];
      end else if (reg_addr == `DDO_REG_OUT2_RISE) begin
        out2_rise_delay_q <= reg_wdata[CW-1:0];
      end else if (reg_addr == `DDO_REG_OUT2_FALL) begin
        out2_fall_delay_q <= reg_wdata[CW-1:0];
      end else if (reg_addr == `DDO_REG_OUT1_FBDLY) begin
        out1_fb_delay_q <= reg_wdata[CW-1:0];
      end else if (reg_addr == `DDO_REG_OUT2_FBDLY) begin
        out2_fb_delay_q <= reg_wdata[CW-1:0];
      end else if (reg_addr == `DDO_REG_CTRL) begin
        ctrl_q <= reg_wdata[19:0];
      end else if (reg_addr == `DDO_REG_SEL1) begin
        free_bit_selector1_q <= reg_wdata[15:0];
      end else if (reg_addr == `DDO_REG_SEL2) begin
        free_bit_selector2_q <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_read) begin
      if (reg_addr == `DDO_REG_OUT1_FUNC) begin
        rdata_q <= {27'h0, out1_function_select_q};
      end else if (reg_addr == `DDO_REG_OUT2_FUNC) begin
        rdata_q <= {27'h0, out2_function_select_q};
      end else if (reg_addr == `DDO_REG_OUT1_RISE) begin
        rdata_q <= 32'(out1_rise_delay_q);
      end else if (reg_addr == `DDO_REG_OUT1_FALL) begin
        rdata_q <= 32'(out1_fall_delay_q);
      end else if (reg_addr == `DDO_REG_OUT2_RISE) begin
        rdata_q <= 32'(out2_rise_delay_q);
      end else if (reg_addr == `DDO_REG_OUT2_FALL) begin
        rdata_q <= 32'(out2_fall_delay_q);
      end else if (reg_addr == `DDO_REG_OUT1_FBDLY) begin
        rdata_q <= 32'(out1_fb_delay_q);
      end else if (reg_addr == `DDO_REG_OUT2_FBDLY) begin
        rdata_q <= 32'(out2_fb_delay_q);
      end else if (reg_addr == `DDO_REG_CTRL) begin
        rdata_q <= {12'h0, ctrl_q};
      end else if (reg_addr == `DDO_REG_SEL1) begin
        rdata_q <= {16'h0, free_bit_selector1_q};
      end else if (reg_addr == `DDO_REG_SEL2) begin
        rdata_q <= {16'h0, free_bit_selector2_q};
      end else if (reg_addr == `DDO_REG_STATUS) begin
        rdata_q <= {27'h0, latched_warning_q, chan_warn, chan_result};
      end else begin
        rdata_q <= '0;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  // set wins over the reset command so a fresh warning is never lost
  always_ff @(posedge clock) begin
    if (rst) begin
      latched_warning_q <= 1'b0;
    end else if (warning_active) begin
      latched_warning_q <= 1'b1;
    end else if (reset_command) begin
      latched_warning_q <= 1'b0;
    end
  end

  // feedback inputs come from pins
  always_ff @(posedge clock) begin
    if (rst) begin
      din_meta_q <= '0;
      din_sync_q <= '0;
    end else begin
      din_meta_q <= digital_inputs;
      din_sync_q <= din_meta_q;
    end
  end

  function automatic logic word_bit_source(input logic [15:0] sel,
                                           input logic [NWORD*16-1:0] words);
    logic [11:0] id;
    logic [3:0] bi;
    id = sel[15:`DDO_SEL_ID_LSB];
    bi = sel[`DDO_SEL_ID_LSB-1:`DDO_SEL_BIT_LSB];
    if (32'(id) < NWORD) begin
      word_bit_source = words[32'(id) * 16 + 32'(bi)];
    end else begin
      word_bit_source = 1'b0;
    end
  endfunction : word_bit_source

  function automatic logic pick(input logic [4:0] fn, input logic [15:0] sel);
    case (fn)
      `DDO_FN_READY: pick = drive_ready;
      `DDO_FN_RUN: pick = drive_running;
      `DDO_FN_FAULT: pick = fault_active;
      `DDO_FN_NOFAULT: pick = !fault_active;
      `DDO_FN_OVERTEMP: pick = drive_overtemp;
      `DDO_FN_EXTALARM: pick = ext_alarm;
      `DDO_FN_REFLOSS: pick = reference_loss;
      `DDO_FN_WARNING: pick = warning_active;
      `DDO_FN_REVERSE: pick = speed_negative;
      `DDO_FN_FIXSPEED: pick = fixed_speed_selected;
      `DDO_FN_ATSPEED: pick = at_speed;
      `DDO_FN_LIMITER: pick = limiter_active;
      `DDO_FN_BRAKE: pick = brake_command;
      `DDO_FN_TERMCTL: pick = terminal_control_active;
      `DDO_FN_WRONGDIR: pick = direction_mismatch;
      `DDO_FN_BRAKEINV: pick = !brake_command;
      `DDO_FN_THERM: pick = thermistor_alarm;
      `DDO_FN_FB1: pick = fieldbus_bits[0];
      `DDO_FN_FB2: pick = fieldbus_bits[1];
      `DDO_FN_FB3: pick = fieldbus_bits[2];
      `DDO_FN_LATCHWARN: pick = latched_warning_q;
      `DDO_FN_WORDBIT: pick = word_bit_source(sel, signal_words);
      default: pick = 1'b0;
    endcase
  endfunction : pick

  // registered source keeps the selection mux off the counter paths
  always_ff @(posedge clock) begin
    if (rst) begin
      src_q <= '0;
    end else begin
      src_q[0] <= pick(out1_function_select_q, free_bit_selector1_q);
      src_q[1] <= pick(out2_function_select_q, free_bit_selector2_q);
    end
  end

  assign dif1.src = src_q[0];
  assign dif1.rise_delay = out1_rise_delay_q;
  assign dif1.fall_delay = out1_fall_delay_q;
  assign dif1.fb_delay = out1_fb_delay_q;
  assign dif1.flip = ctrl_q[`DDO_CTL_FLIP1];
  assign dif1.fb_enable = ctrl_q[`DDO_CTL_FBEN1];
  assign dif1.fb_level = din_sync_q[ctrl_q[`DDO_CTL_FBSEL1_LSB +: 4] % NDIN];
  assign dif2.src = src_q[1];
  assign dif2.rise_delay = out2_rise_delay_q;
  assign dif2.fall_delay = out2_fall_delay_q;
  assign dif2.fb_delay = out2_fb_delay_q;
  assign dif2.flip = ctrl_q[`DDO_CTL_FLIP2];
  assign dif2.fb_enable = ctrl_q[`DDO_CTL_FBEN2];
  assign dif2.fb_level = din_sync_q[ctrl_q[`DDO_CTL_FBSEL2_LSB +: 4] % NDIN];
  assign chan_result = {dif2.result, dif1.result};
  assign chan_warn = {dif2.fb_warning, dif1.fb_warning};

  ddo_delay_chan #(.CW(CW)) u_chan1 (
    .clock(clock),
    .rst(rst),
    .tick(tick_q),
    .ch(dif1)
  );

  ddo_delay_chan #(.CW(CW)) u_chan2 (
    .clock(clock),
    .rst(rst),
    .tick(tick_q),
    .ch(dif2)
  );

  // both outputs routed to one terminal are ored together
  genvar t;
  generate
    for (t = 0; t < NTERM; t++) begin : g_term
      always_ff @(posedge clock) begin
        if (rst) begin
          term_q[t] <= 1'b0;
        end else begin
          term_q[t] <= (chan_result[0] && (32'(ctrl_q[`DDO_CTL_ROUTE1_LSB +: 4]) == t + 1))
                    || (chan_result[1] && (32'(ctrl_q[`DDO_CTL_ROUTE2_LSB +: 4]) == t + 1));
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      fbw_q <= '0;
    end else begin
      fbw_q <= chan_warn;
    end
  end

  assign reg_rdata = rdata_q;
  assign terminal_out = term_q;
  assign out1_feedback_warning = fbw_q[0];
  assign out2_feedback_warning = fbw_q[1];
endmodule : ddo_selector

// File: ddo_selector_asserts.sv
// concurrent checks on the selector top ports
`timescale 1ns/1ns
module ddo_selector_chk #(
  parameter int NTERM = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic drive_ready,
  input wire logic [NTERM-1:0] terminal_out,
  input wire logic out1_feedback_warning,
  input wire logic out2_feedback_warning
);
  logic [4:0] fn1_q;
  logic [19:0] ctl_q;
  logic [31:0] dly_q;
  logic base1;
  logic rdy1;
  // shadow of config writes, so checks know what feeds terminal one
  always_ff @(posedge clock) begin
    if (rst) fn1_q <= 5'h00;
    else if (reg_write && reg_addr == 4'h0) fn1_q <= reg_wdata[4:0];
  end
  always_ff @(posedge clock) begin
    if (rst) ctl_q <= 20'h00000;
    else if (reg_write && reg_addr == 4'h8) ctl_q <= reg_wdata[19:0];
  end
  always_ff @(posedge clock) begin
    if (rst) dly_q <= 32'h0000_0000;
    else if (reg_write && reg_addr == 4'h2) dly_q[15:0] <= reg_wdata[15:0];
    else if (reg_write && reg_addr == 4'h3) dly_q[31:16] <= reg_wdata[15:0];
  end
  assign base1 = ctl_q[7:4] == 4'h1 && ctl_q[11:8] != 4'h1 && dly_q == 32'h0000_0000;
  assign rdy1 = base1 && fn1_q == 5'h01 && !ctl_q[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rise; rdy1 && $rose(drive_ready); endsequence
  sequence s_high; (rdy1 && drive_ready)[*7]; endsequence
  sequence s_fall; rdy1 && $fell(drive_ready); endsequence
  sequence s_low; (rdy1 && !drive_ready)[*7]; endsequence
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=> terminal_out == '0
    && !out1_feedback_warning && !out2_feedback_warning && reg_rdata == 32'h0)
    else $error("outputs not quiet after reset");
  AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  AST_READY_RISE: assert property (s_rise ##1 s_high |-> terminal_out[0])
    else $error("ready not shown on terminal");
  AST_READY_FALL: assert property (s_fall ##1 s_low |-> !terminal_out[0])
    else $error("terminal stays on after ready drops");
  AST_FLIP_OFF: assert property ((base1 && fn1_q == 5'h00 && ctl_q[0])[*8]
    |-> terminal_out[0])
    else $error("inversion of idle source missing");
  AST_IDLE_LOW: assert property ((base1 && fn1_q == 5'h00 && !ctl_q[0])[*8]
    |-> !terminal_out[0])
    else $error("unused code drives terminal");
  AST_UNROUTED: assert property ((ctl_q[7:4] != NTERM && ctl_q[11:8] != NTERM)[*8]
    |-> !terminal_out[NTERM-1])
    else $error("unrouted terminal active");
  AST_FB_ENABLED: assert property ($rose(out1_feedback_warning)
    |-> ctl_q[2] || $past(ctl_q[2]) || $past(ctl_q[2], 2))
    else $error("feedback warning while watch disabled");
endmodule : ddo_selector_chk
bind ddo_selector ddo_selector_chk #(.NTERM(NTERM)) u_chk (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .drive_ready(drive_ready), .terminal_out(terminal_out),
  .out1_feedback_warning(out1_feedback_warning),
  .out2_feedback_warning(out2_feedback_warning));

// File: ddo_contact_model.sv
// relay contact wired back from an output terminal to a digital input
`timescale 1ns/1ns
module ddo_contact_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic coil,
  input wire logic stuck,
  output logic contact
);
  logic [2:0] lag_q;
  // contact settles a few cycles after its coil
  always_ff @(posedge clock) begin
    if (rst) lag_q <= 3'h0;
    else lag_q <= {lag_q[1:0], coil};
  end
  // a welded or open contact shows the opposite of the coil
  assign contact = stuck ? ~coil : lag_q[2];
endmodule : ddo_contact_model

// File: ddo_selector_bench.sv
// self-checking bench for the delayed output selector
`timescale 1ns/1ns
module ddo_selector_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [17:0] st = 18'h00000;
  logic reset_command = 1'b0;
  logic [255:0] words = '0;
  logic stuck = 1'b0;
  logic contact;
  logic [7:0] tout;
  logic w1;
  logic w2;
  logic iv;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [4:0] fc [20] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h0A, 5'h0B, 5'h0C, 5'h11, 5'h12, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A};
  int ix [20] = '{0, 1, 2, 2, 4, 5, 6, 3, 7, 8, 9, 10, 11, 12, 13, 11, 14, 15, 16, 17};
  logic [4:0] unused [8] = '{5'h00, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h13, 5'h17, 5'h1D};
  always #5 clock = ~clock;
  ddo_selector #(.TICK_DIV(4)) uut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .drive_ready(st[0]), .drive_running(st[1]),
    .fault_active(st[2]), .warning_active(st[3]), .drive_overtemp(st[4]),
    .ext_alarm(st[5]), .reference_loss(st[6]), .speed_negative(st[7]),
    .fixed_speed_selected(st[8]), .at_speed(st[9]), .limiter_active(st[10]),
    .brake_command(st[11]), .terminal_control_active(st[12]),
    .direction_mismatch(st[13]), .thermistor_alarm(st[14]), .fieldbus_bits(st[17:15]),
    .reset_command(reset_command), .signal_words(words),
    .digital_inputs({5'h00, contact, 2'h0}), .terminal_out(tout),
    .out1_feedback_warning(w1), .out2_feedback_warning(w2));
  ddo_contact_model u_contact (.clock(clock), .rst(rst), .coil(tout[0]), .stuck(stuck),
    .contact(contact));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic pin(input string nm, input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : pin
  task automatic word(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : word
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    // data stands only until the next edge, so look mid-cycle
    @(negedge clock);
    word("rdata", reg_rdata, exp);
    @(posedge clock);
  endtask : rd
  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(4'h6, 32'h0000_0BB8);
    rd(4'hC, 32'h0000_0000);
    wr(4'hB, 32'hFFFF_FFFF);
    rd(4'hB, 32'h0000_0000);
    wr(4'h2, 32'h0001_0005);
    rd(4'h2, 32'h0000_0005);
    wr(4'h2, 32'h0000_0000);
    wr(4'h5, 32'h0000_0007);
    rd(4'h5, 32'h0000_0007);
    wr(4'h5, 32'h0000_0000);
    $display("test registers done");
    wr(4'h8, 32'h0000_0010);
    for (int i = 0; i < 20; i++) begin
      iv = fc[i] == 5'h04 || fc[i] == 5'h15;
      wr(4'h0, {27'h0, fc[i]});
      st <= ~(18'h1 << ix[i]);
      cyc(10);
      pin("source idle", tout[0], iv);
      st <= 18'h3FFFF;
      cyc(10);
      pin("source on", tout[0], !iv);
      st <= ~(18'h1 << ix[i]);
      cyc(10);
      pin("source off", tout[0], iv);
    end
    $display("test function codes done");
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, {27'h0, unused[i]});
      cyc(10);
      pin("unused code", tout[0], 1'b0);
    end
    wr(4'h0, 32'h0000_0000);
    wr(4'h8, 32'h0000_0011);
    cyc(10);
    pin("inverted idle", tout[0], 1'b1);
    $display("test unused and inversion done");
    wr(4'h1, 32'h0000_0002);
    wr(4'h0, 32'h0000_0001);
    wr(4'h8, 32'h0000_0350);
    st <= 18'h00001;
    cyc(10);
    word("terminals", {24'h0, tout}, 32'h0000_0010);
    st <= 18'h00002;
    cyc(10);
    word("terminals", {24'h0, tout}, 32'h0000_0004);
    wr(4'h8, 32'h0000_0010);
    $display("test routing done");
    wr(4'h0, 32'h0000_001B);
    st <= 18'h00000;
    reset_command <= 1'b1;
    cyc(2);
    reset_command <= 1'b0;
    cyc(10);
    pin("latch clear", tout[0], 1'b0);
    st <= 18'h00008;
    cyc(2);
    reset_command <= 1'b1;
    cyc(2);
    reset_command <= 1'b0;
    st <= 18'h00000;
    cyc(10);
    pin("latch held", tout[0], 1'b1);
    rd(4'hB, 32'h0000_0011);
    reset_command <= 1'b1;
    cyc(2);
    reset_command <= 1'b0;
    cyc(10);
    pin("latch reset", tout[0], 1'b0);
    $display("test latched warning done");
    wr(4'h0, 32'h0000_001C);
    wr(4'h9, 32'h0000_0035);
    words <= ~(256'h1 << 53);
    cyc(10);
    pin("word bit low", tout[0], 1'b0);
    words <= 256'h1 << 53;
    cyc(10);
    pin("word bit high", tout[0], 1'b1);
    words <= '0;
    $display("test word bit done");
    wr(4'h0, 32'h0000_0001);
    cyc(10);
    wr(4'h2, 32'h0000_0003);
    wr(4'h3, 32'h0000_0002);
    st <= 18'h00001;
    cyc(6);
    st <= 18'h00000;
    cyc(40);
    pin("short pulse", tout[0], 1'b0);
    st <= 18'h00001;
    cyc(8);
    pin("rise waiting", tout[0], 1'b0);
    cyc(30);
    pin("rise done", tout[0], 1'b1);
    st <= 18'h00000;
    cyc(6);
    pin("fall waiting", tout[0], 1'b1);
    cyc(30);
    pin("fall done", tout[0], 1'b0);
    wr(4'h2, 32'h0000_0000);
    wr(4'h3, 32'h0000_0000);
    $display("test delays done");
    wr(4'h6, 32'h0000_0005);
    wr(4'h8, 32'h0000_2014);
    st <= 18'h00001;
    cyc(60);
    pin("fb follows", w1, 1'b0);
    stuck <= 1'b1;
    cyc(8);
    pin("fb early", w1, 1'b0);
    cyc(40);
    pin("fb warning", w1, 1'b1);
    pin("fb2 quiet", w2, 1'b0);
    rd(4'hB, 32'h0000_0005);
    stuck <= 1'b0;
    cyc(15);
    pin("fb cleared", w1, 1'b0);
    $display("test feedback done");
    conclude();
  end
endmodule : ddo_selector_bench
